// [rtl/host_port.sv]
// Multimode host access port: serial shift, strobe-pair and direction-strobe buses.
// Assumes static select straps and a core register space on the reg_* side.
//
// Function
// - Bus-mux select low gives separate address bus, open gives multiplexed bus.
// - Strobe-pair multiplexed: address from A[10:8], D[7:0] at latch falling edge.
// - Direction-strobe multiplexed: address from A[10:8], D[7:0] at address strobe fall.
// - Serial address and data are taken on rising shift clock edges.
// - Serial read data changes only on falling shift clock edges.
// - Data strobe low: direction 0 samples data, direction 1 drives data.
// - Read strobe low starts a read; device drives the requested byte.
// - Write strobe low starts a write; device samples the data bus.
// - Acknowledge goes low for valid read data or accepted write data.
// - Ready high tells the host the cycle may finish.
// - Ready stays low while the cycle cannot complete; host waits.
// - Port type select low is serial, high is parallel.
// - Style select low is direction-strobe, open is strobe-pair.
`timescale 1ns/10ps
module host_port (
	input  wire logic                              ref_clk,
	input  wire logic                              rst_n,
	input  wire logic                              cs_n,
	input  wire logic                              port_sel,
	input  wire logic                              strobe_style_sel,
	input  wire logic                              bus_mux_select,
	input  wire logic                              addr_strobe_n,
	input  wire logic                              sclk_strobe,
	input  wire logic                              serial_in_dir,
	input  wire logic [host_port_pkg::ADDR_W-1:0]  addr_in,
	input  wire logic [host_port_pkg::DATA_W-1:0]  data_in,
	output logic      [host_port_pkg::DATA_W-1:0]  data_out,
	output logic                                   data_oe,
	output logic                                   resp_out,
	output logic                                   resp_oe,
	output logic      [host_port_pkg::ADDR_W-1:0]  reg_addr,
	output logic      [host_port_pkg::DATA_W-1:0]  reg_wdata,
	output logic                                   reg_wr,
	output logic                                   reg_rd,
	input  wire logic [host_port_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                              reg_rd_ack
);
	typedef enum logic [1:0] {P_IDLE, P_RD_WAIT, P_HOLD} par_state_t;

	// Pin sampling
	logic [host_port_pkg::PIN_W-1:0] sync1_r;
	logic [host_port_pkg::PIN_W-1:0] sync2_r;
	logic                            strobe_prev_r;
	logic                            as_prev_r;

	// Synchronised views
	logic                            cs_act;
	logic                            par_mode;
	logic                            pair_style;
	logic                            mux_mode;
	logic                            as_s;
	logic                            stb_s;
	logic                            dir_s;
	logic [host_port_pkg::ADDR_W-1:0] a_s;
	logic [host_port_pkg::DATA_W-1:0] d_s;

	// Parallel engine
	par_state_t                      pst_r;
	logic [host_port_pkg::ADDR_W-1:0] addr_lat_r;
	logic [host_port_pkg::ADDR_W-1:0] par_addr;
	logic                            p_rd_req;
	logic                            p_wr_req;
	logic                            p_end;
	logic                            as_fall;

	// Serial engine
	logic                            sclk_rise;
	logic                            sclk_fall;
	logic                            serial_out;
	logic                            sdo_en;

	host_access_if acc ();

	// Every pin is asynchronous to ref_clk; the shift clock is slow enough to sample
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {cs_n, port_sel, strobe_style_sel, bus_mux_select,
			            addr_strobe_n, sclk_strobe, serial_in_dir, addr_in, data_in};
			sync2_r <= sync1_r;
		end
	end

	assign d_s        = sync2_r[host_port_pkg::DATA_W-1:0];
	assign a_s        = sync2_r[host_port_pkg::DATA_W +: host_port_pkg::ADDR_W];
	assign dir_s      = sync2_r[host_port_pkg::PIN_W-7];
	assign stb_s      = sync2_r[host_port_pkg::PIN_W-6];
	assign as_s       = sync2_r[host_port_pkg::PIN_W-5];
	assign mux_mode   = sync2_r[host_port_pkg::PIN_W-4] != host_port_pkg::SEL_NON_MUX;
	assign pair_style = sync2_r[host_port_pkg::PIN_W-3] != host_port_pkg::SEL_DIR_STB;
	assign par_mode   = sync2_r[host_port_pkg::PIN_W-2] != host_port_pkg::SEL_SERIAL;
	assign cs_act     = !sync2_r[host_port_pkg::PIN_W-1];

	// Edge history; reset level matches the flushed sync stages, so no false falling edge follows reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			strobe_prev_r <= 1'b0;
			as_prev_r     <= 1'b0;
		end else begin
			strobe_prev_r <= stb_s;
			as_prev_r     <= as_s;
		end
	end

	assign sclk_rise = stb_s && !strobe_prev_r;
	assign sclk_fall = !stb_s && strobe_prev_r;
	assign as_fall   = !as_s && as_prev_r;

	// Multiplexed address: upper lines plus the data bus, low lines ignored
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			addr_lat_r <= host_port_pkg::ADDR_RST;
		else if (par_mode && mux_mode && as_fall)
			addr_lat_r <= {a_s[host_port_pkg::ADDR_W-1 -: host_port_pkg::MUX_HI_W], d_s};
	end

	// In non-multiplexed modes the address strobe is assumed held high
	assign par_addr = mux_mode ? addr_lat_r : a_s;

	// Start and end of a parallel cycle; requests are gated off without chip select or parallel mode
	always_comb begin
		if (pair_style) begin
			p_rd_req = !stb_s;
			p_wr_req = !dir_s;
			p_end    = stb_s && dir_s;
		end else begin
			p_rd_req = !stb_s && dir_s;
			p_wr_req = !stb_s && !dir_s;
			p_end    = stb_s;
		end
		if (!cs_act || !par_mode) begin
			p_rd_req = 1'b0;
			p_wr_req = 1'b0;
			p_end    = 1'b1;
		end
	end

	// Parallel cycle sequencer: wait for read data, then hold until strobe release
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pst_r <= P_IDLE;
		end else begin
			case (pst_r)
				P_IDLE: begin
					if (p_rd_req)
						pst_r <= P_RD_WAIT;
					else if (p_wr_req)
						pst_r <= P_HOLD;
				end
				P_RD_WAIT: begin
					if (!cs_act || !par_mode)
						pst_r <= P_IDLE;
					else if (reg_rd_ack)
						pst_r <= P_HOLD;
				end
				P_HOLD: begin
					if (p_end)
						pst_r <= P_IDLE;
				end
				default: pst_r <= P_IDLE;
			endcase
		end
	end

	// Requests toward the register space, registered from whichever engine is live
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rd    <= 1'b0;
			reg_wr    <= 1'b0;
			reg_addr  <= host_port_pkg::ADDR_RST;
			reg_wdata <= host_port_pkg::DATA_RST;
		end else if (par_mode) begin
			reg_rd    <= pst_r == P_IDLE && p_rd_req;
			reg_wr    <= pst_r == P_IDLE && !p_rd_req && p_wr_req;
			reg_addr  <= par_addr;
			reg_wdata <= d_s;
		end else begin
			reg_rd    <= acc.rd;
			reg_wr    <= acc.wr;
			reg_addr  <= acc.addr;
			reg_wdata <= acc.wdata;
		end
	end

	// Read data comes back on the core clock; only the serial engine needs it forwarded
	assign acc.rdata  = reg_rdata;
	assign acc.rd_ack = reg_rd_ack && !par_mode;

	serial_engine u_serial (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.frame_on  (cs_act && !par_mode),
		.sclk_rise (sclk_rise),
		.sclk_fall (sclk_fall),
		.serial_in       (dir_s),
		.acc       (acc),
		.sdo_r     (serial_out),
		.sdo_en_r  (sdo_en)
	);

	// Data bus drivers: on only from read data arrival to strobe release
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			data_out <= host_port_pkg::DATA_RST;
			data_oe  <= 1'b0;
		end else if (pst_r == P_RD_WAIT && reg_rd_ack && cs_act && par_mode) begin
			data_out <= reg_rdata;
			data_oe  <= 1'b1;
		end else if (pst_r != P_HOLD || p_end) begin
			data_oe  <= 1'b0;
		end
	end

	// Shared response pin: ready, acknowledge or serial output by mode
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			resp_out <= 1'b1;
			resp_oe  <= 1'b0;
		end else if (!par_mode) begin
			resp_out <= serial_out;
			resp_oe  <= sdo_en;
		end else if (pair_style) begin
			// Ready low until the cycle is done, so a slow core simply stretches it
			resp_out <= pst_r == P_HOLD && !p_end;
			resp_oe  <= cs_act;
		end else begin
			resp_out <= !(pst_r == P_HOLD && !p_end);
			resp_oe  <= cs_act;
		end
	end

endmodule : host_port

// [rtl/host_port_pkg.sv]
// Shared constants for the multimode host access port.
// Assumes a single 100 MHz core clock; all pin timing is derived from it.
package host_port_pkg;

	// Bus widths
	localparam int unsigned ADDR_W      = 11;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned MUX_HI_W    = 3;   // Upper address lines used in multiplexed mode

	// Pin synchroniser depth and width
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned PIN_W       = 7 + ADDR_W + DATA_W;

	// Serial frame layout: direction bit, address, data, all MSB first
	localparam int unsigned SER_CNT_W   = 5;
	localparam logic [4:0]  SER_HDR_END = 5'h0c;  // Bits taken after the address
	localparam logic [4:0]  SER_FRM_END = 5'h14;  // Bits taken after the data
	localparam logic        SER_DIR_RD  = 1'h1;

	// Values after reset
	localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [4:0]        CNT_RST  = 5'h00;

	// Pin polarity coding of the static selects
	localparam logic SEL_SERIAL    = 1'h0;  // Port type select tied to ground
	localparam logic SEL_DIR_STB   = 1'h0;  // Style select tied to ground
	localparam logic SEL_NON_MUX   = 1'h0;  // Bus-mux select tied to ground

endpackage : host_port_pkg

// [rtl/host_access_if.sv]
// Internal request channel between the serial engine and the port core.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface host_access_if;
	logic                              rd;
	logic                              wr;
	logic [host_port_pkg::ADDR_W-1:0]  addr;
	logic [host_port_pkg::DATA_W-1:0]  wdata;
	logic [host_port_pkg::DATA_W-1:0]  rdata;
	logic                              rd_ack;

	modport engine (output rd, output wr, output addr, output wdata,
	                input rdata, input rd_ack);
	modport core   (input rd, input wr, input addr, input wdata,
	                output rdata, output rd_ack);
endinterface : host_access_if

// [rtl/serial_engine.sv]
// Serial shift engine of the host port.
// Assumes already synchronised pins and one-cycle shift clock edge pulses.
`timescale 1ns/10ps
module serial_engine (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic          frame_on,
	input  wire logic          sclk_rise,
	input  wire logic          sclk_fall,
	input  wire logic          serial_in,
	host_access_if.engine      acc,
	output logic               sdo_r,
	output logic               sdo_en_r
);
	logic [host_port_pkg::SER_CNT_W-1:0] cnt_r;
	logic [host_port_pkg::ADDR_W:0]      hdr_r;     // Direction bit then address
	logic [host_port_pkg::DATA_W-1:0]    wsh_r;
	logic [host_port_pkg::DATA_W-1:0]    rhold_r;
	logic                                rd_r;
	logic                                wr_r;
	logic                                is_rd;
	logic [2:0]                          bit_idx;

	assign is_rd   = (hdr_r[host_port_pkg::ADDR_W] == host_port_pkg::SER_DIR_RD);
	assign bit_idx = 3'(host_port_pkg::SER_FRM_END - 5'h01 - cnt_r);
	assign acc.rd    = rd_r;
	assign acc.wr    = wr_r;
	assign acc.addr  = hdr_r[host_port_pkg::ADDR_W-1:0];
	assign acc.wdata = wsh_r;

	// Bits are taken only on rising shift clock edges
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !frame_on) begin
			cnt_r <= host_port_pkg::CNT_RST;
			hdr_r <= '0;
			wsh_r <= host_port_pkg::DATA_RST;
		end else if (sclk_rise && cnt_r != host_port_pkg::SER_FRM_END) begin
			cnt_r <= cnt_r + 5'h01;
			if (cnt_r < host_port_pkg::SER_HDR_END)
				hdr_r <= {hdr_r[host_port_pkg::ADDR_W-1:0], serial_in};
			else
				wsh_r <= {wsh_r[host_port_pkg::DATA_W-2:0], serial_in};
		end
	end

	// One request per frame, issued as the header or the data completes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
		end else begin
			rd_r <= frame_on && sclk_rise && cnt_r == host_port_pkg::SER_HDR_END - 5'h01
			        && hdr_r[host_port_pkg::ADDR_W-1] == host_port_pkg::SER_DIR_RD;
			wr_r <= frame_on && sclk_rise && cnt_r == host_port_pkg::SER_FRM_END - 5'h01
			        && !is_rd;
		end
	end

	// Read data is held so the output stays stable through the frame
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			rhold_r <= host_port_pkg::DATA_RST;
		else if (acc.rd_ack)
			rhold_r <= acc.rdata;
	end

	// Output moves only on falling edges; it floats until a read's data phase, then stays driven until the frame ends
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !frame_on) begin
			sdo_r    <= 1'b0;
			sdo_en_r <= 1'b0;
		end else if (sclk_fall && is_rd && cnt_r >= host_port_pkg::SER_HDR_END
		             && cnt_r < host_port_pkg::SER_FRM_END) begin
			sdo_r    <= rhold_r[bit_idx];
			sdo_en_r <= 1'b1;
		end
	end

endmodule : serial_engine

// [verif/host_port_checker.sv]
// Concurrent checks on the host port pins and the core request side.
// Assumes one core clock domain; bound onto every host_port.
`timescale 1ns/10ps
module host_port_checker (
	input logic                                ref_clk,
	input logic                                rst_n,
	input logic                                port_sel,
	input logic                                strobe_style_sel,
	input logic                                sclk_strobe,
	input logic [host_port_pkg::DATA_W-1:0]    data_out,
	input logic                                data_oe,
	input logic                                resp_out,
	input logic                                resp_oe,
	input logic                                reg_rd,
	input logic                                reg_wr,
	input logic [host_port_pkg::DATA_W-1:0]    reg_rdata,
	input logic                                reg_rd_ack
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Parallel read answered by the core within eight cycles
	sequence s_rd_done;
		port_sel && reg_rd ##[1:8] reg_rd_ack;
	endsequence
	a_rd_one_pulse: assert property (reg_rd |=> !reg_rd) else $error("read pulse too long");
	a_wr_one_pulse: assert property (reg_wr |=> !reg_wr) else $error("write pulse too long");
	a_rd_wr_apart: assert property (!(reg_rd && reg_wr)) else $error("read and write at once");
	a_read_data_out: assert property (s_rd_done |=> data_oe && data_out == $past(reg_rdata))
		else $error("read byte not driven");
	// Handshake pin lags the bus enable by one edge at the start and drops with it at the end
	a_ack_low: assert property (port_sel && !strobe_style_sel && data_oe && $past(data_oe)
		|-> !resp_out) else $error("acknowledge missing");
	a_ready_high: assert property (port_sel && strobe_style_sel && data_oe && $past(data_oe)
		|-> resp_out) else $error("ready missing");
	a_ready_wait: assert property (port_sel && strobe_style_sel && reg_rd |=> resp_oe && !resp_out)
		else $error("ready high too early");
	a_bus_float_ser: assert property (!port_sel |-> !data_oe) else $error("bus driven in serial");
	// Sync delay is two or three cycles, so the pin was low two cycles back
	a_sdo_fall_edge: assert property (!port_sel && resp_oe && $past(resp_oe) && $changed(resp_out)
		|-> !$past(sclk_strobe, 2)) else $error("serial out moved off a falling edge");
endmodule : host_port_checker
bind host_port host_port_checker u_chk (.ref_clk, .rst_n, .port_sel, .strobe_style_sel,
	.sclk_strobe, .data_out, .data_oe, .resp_out, .resp_oe, .reg_rd, .reg_wr, .reg_rdata,
	.reg_rd_ack);

// [verif/host_cpu_model.sv]
// Host processor model driving the port pins in all three bus styles.
// Assumes the bench calls its tasks; pins change on falling clock edges.
`timescale 1ns/10ps
module host_cpu_model (
	input  logic        ref_clk,
	input  logic [7:0]  data_out,
	input  logic        data_oe,
	input  logic        resp_out,
	input  logic        resp_oe,
	output logic        cs_n,
	output logic        port_sel,
	output logic        strobe_style_sel,
	output logic        bus_mux_select,
	output logic        addr_strobe_n,
	output logic        sclk_strobe,
	output logic        serial_in_dir,
	output logic [10:0] addr_in,
	output logic [7:0]  data_in
);
	logic [7:0] hd;
	logic       hen;
	// Released bus drifts to the inverse so stale data never passes
	assign data_in = data_oe ? data_out : (hen ? hd : ~hd);
	initial begin
		{cs_n, port_sel, strobe_style_sel, bus_mux_select} = 4'h9;
		{addr_strobe_n, sclk_strobe, serial_in_dir, hen} = 4'h0;
		addr_in = 11'h000;
		hd = 8'h00;
	end
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : step
	// Straps only change between resets
	task automatic straps(input logic p, input logic s, input logic m);
		port_sel = p;
		strobe_style_sel = s;
		bus_mux_select = p & m;
		addr_strobe_n = p;
		sclk_strobe = p;
		serial_in_dir = p;
	endtask : straps
	// One parallel transfer; ok low means the handshake never came
	task automatic par(input logic rd, input logic [10:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int n;
		cs_n = 1'b0;
		addr_in = a;
		if (bus_mux_select) begin
			addr_in = {a[10:8], 8'h00};
			hd = a[7:0];
			hen = 1'b1;
			step(1);
			addr_strobe_n = 1'b0;
			step(6);
			addr_strobe_n = 1'b1;
		end
		step(1);
		hd = d;
		hen = !rd;
		if (strobe_style_sel) begin
			if (rd) sclk_strobe = 1'b0;
			else serial_in_dir = 1'b0;
		end else begin
			serial_in_dir = rd;
			sclk_strobe = 1'b0;
		end
		step(3);
		ok = 1'b0;
		for (n = 0; n < 100 && !ok; n++) begin
			// Sampled at the falling edge, where registered outputs have settled
			step(1);
			ok = resp_oe && resp_out === strobe_style_sel && (!rd || data_oe);
			q = data_out;
		end
		step(1);
		{sclk_strobe, serial_in_dir, cs_n, hen} = 4'he;
		step(5);
	endtask : par
	// Serial frame: direction, eleven address bits, eight data bits
	task automatic ser(input logic rd, input logic [10:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [19:0] b;
		b = {rd, a, d};
		cs_n = 1'b0;
		step(2);
		for (int i = 19; i >= 0; i--) begin
			sclk_strobe = 1'b0;
			serial_in_dir = b[i];
			step(4);
			if (i < 8) q[i] = resp_oe ? resp_out : ~resp_out;
			sclk_strobe = 1'b1;
			step(4);
		end
		sclk_strobe = 1'b0;
		serial_in_dir = ~b[0];
		step(4);
		cs_n = 1'b1;
		step(4);
	endtask : ser
endmodule : host_cpu_model

// [verif/test_multimode_host_port_pins.sv]
// Self-checking bench: host model on the pins, core model on the reg side.
// Assumes host_port, its checker bind and the host model are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_multimode_host_port_pins;
	logic        ref_clk, rst_n, cs_n, port_sel, strobe_style_sel, bus_mux_select;
	logic        addr_strobe_n, sclk_strobe, serial_in_dir, data_oe, resp_out, resp_oe;
	logic        reg_wr, reg_rd, reg_rd_ack, slow, ok;
	logic [10:0] addr_in, reg_addr, ra, wa;
	logic [7:0]  data_in, data_out, reg_wdata, reg_rdata, wd, q;
	int          n_errors, num_checks, pend;
	host_port DUT (.ref_clk, .rst_n, .cs_n, .port_sel, .strobe_style_sel, .bus_mux_select,
		.addr_strobe_n, .sclk_strobe, .serial_in_dir, .addr_in, .data_in, .data_out, .data_oe,
		.resp_out, .resp_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rd_ack);
	host_cpu_model u_host (.ref_clk, .data_out, .data_oe, .resp_out, .resp_oe, .cs_n, .port_sel,
		.strobe_style_sel, .bus_mux_select, .addr_strobe_n, .sclk_strobe, .serial_in_dir,
		.addr_in, .data_in);
	always #5 ref_clk = ~ref_clk;
	// Core model: answers a read in the read pulse's own cycle, or five cycles later when slow
	always @(negedge ref_clk) begin
		reg_rd_ack = 1'b0;
		if (reg_rd) begin
			pend = slow ? 6 : 1;
			ra = reg_addr;
		end
		// Answer when the countdown runs out, in the read pulse's own cycle unless slow
		if (pend > 0) begin
			pend--;
			if (pend == 0) begin
				reg_rd_ack = 1'b1;
				reg_rdata = ra[7:0] ^ 8'h5a;
			end
		end
		if (reg_wr) {wa, wd} = {reg_addr, reg_wdata};
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic do_reset();
		rst_n = 1'b0;
		u_host.step(4);
		rst_n = 1'b1;
		u_host.step(3);
		// Idle handshake level: acknowledge inactive high, ready low, serial output low
		`CHK({data_oe, resp_oe, resp_out}, {2'h0, port_sel && !strobe_style_sel})
	endtask : do_reset
	// Serial write then read, sampled on rising and shifted on falling edges
	task automatic t_serial();
		u_host.straps(1'b0, 1'b1, 1'b0);
		do_reset();
		u_host.ser(1'b0, 11'h5a3, 8'hc6, q);
		`CHK({wa, wd}, {11'h5a3, 8'hc6})
		u_host.ser(1'b1, 11'h2b1, 8'h00, q);
		`CHK(ra, 11'h2b1)
		`CHK(q, 8'hb1 ^ 8'h5a)
		`CHK(resp_oe, 1'b0)
	endtask : t_serial
	// Parallel write then slow read in one style and address scheme
	task automatic t_parallel(input logic s, input logic m);
		u_host.straps(1'b1, s, m);
		do_reset();
		u_host.par(1'b0, {s, m, 9'h1b6}, {6'h2d, s, m}, q, ok);
		`CHK(ok, 1'b1)
		if (!ok) end_of_test();
		`CHK({wa, wd}, {s, m, 9'h1b6, 6'h2d, s, m})
		slow = 1'b1;
		u_host.par(1'b1, {m, s, 9'h0c9}, 8'h00, q, ok);
		slow = 1'b0;
		`CHK(ok, 1'b1)
		if (!ok) end_of_test();
		`CHK(ra, {m, s, 9'h0c9})
		`CHK(q, 8'hc9 ^ 8'h5a)
		`CHK(data_oe, 1'b0)
	endtask : t_parallel
	initial begin
		{ref_clk, rst_n, reg_rd_ack, slow, pend} = 0;
		reg_rdata = 8'h00;
		// Let the host model's power-up values settle before the straps are set
		u_host.step(1);
		t_serial();
		t_parallel(1'b1, 1'b0);
		t_parallel(1'b1, 1'b1);
		t_parallel(1'b0, 1'b0);
		t_parallel(1'b0, 1'b1);
		end_of_test();
	end
endmodule : test_multimode_host_port_pins
